//--- common/smc_pkg.sv
// Standby mode control constants, register map and enumerations.
// Assumes a 20 MHz system clock and an APB register bus.
package smc_pkg;
    // Register byte offsets
    localparam logic [7:0] SMC_CTRL_OFS = 8'h00;
    localparam logic [7:0] SMC_CFG_OFS = 8'h04;
    localparam logic [7:0] SMC_STAT_OFS = 8'h08;
    localparam logic [7:0] SMC_CLKSEL_OFS = 8'h0C;
    // Control register fields
    localparam int SMC_CTRL_HALT_BIT = 0;
    localparam int SMC_CTRL_STOP_BIT = 1;
    localparam int SMC_CTRL_IOSC_OFF_BIT = 2;
    // Configuration register fields
    localparam int SMC_CFG_SETTLE_LSB = 0;
    localparam int SMC_CFG_SETTLE_W = 3;
    localparam int SMC_CFG_RC_BIT = 3;
    localparam int SMC_CFG_IOSC_LOCK_BIT = 4;
    localparam int SMC_CFG_CPU_IOSC_BIT = 5;
    // Peripheral clock select fields
    localparam int SMC_SEL_T50_EXT_BIT = 0;
    localparam int SMC_SEL_T50_RUN_BIT = 1;
    localparam int SMC_SEL_H0_T50_BIT = 2;
    localparam int SMC_SEL_H1_DIV7_BIT = 3;
    localparam int SMC_SEL_UART_T50_BIT = 4;
    localparam int SMC_SEL_CSI_EXT_BIT = 5;
    // Reset values
    localparam logic [31:0] SMC_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] SMC_CLKSEL_RST = 32'h0000_0000;
    // Wake waits in cycles
    localparam logic [3:0] SMC_WAIT_VECTOR = 4'h8;
    localparam logic [3:0] SMC_WAIT_NEXT = 4'h2;
    // Base settle count; select n gives base shifted by n
    localparam logic [15:0] SMC_SETTLE_BASE = 16'h0010;
    // Standby states
    typedef enum logic [2:0] {
        SMC_RUN, SMC_HALT, SMC_STOP, SMC_SETTLE, SMC_WAKE
    } smc_state_t;
    // Wake outcomes
    typedef enum logic [1:0] {
        SMC_ACT_HOLD, SMC_ACT_NEXT, SMC_ACT_SERVICE
    } smc_act_t;
endpackage

//--- rtl/smc_top.sv
// Standby controller: halt, stop, wake decision and stop clock gating.
// Assumes the core raises one-cycle halt/stop strobes and presents the
// winning request's mask and priority flags; inputs synchronous.
`timescale 1ns/100ps
module smc_top
    import smc_pkg::*;
#(
    parameter int SETTLE_MAX_SEL = 7
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Core standby strobes and interrupt status
    input wire logic HALT_INSN,
    input wire logic STOP_INSN,
    input wire logic IRQ_PENDING,
    input wire logic SOURCE_MASK_FLAG,
    input wire logic SOURCE_PRIORITY_FLAG,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic IN_SERVICE_PRIORITY,
    // Port latch input
    input wire logic [7:0] PORT_LATCH_IN,
    // Core wake controls
    output logic CPU_CLK_EN,
    output logic WAKE_NEXT,
    output logic WAKE_SERVICE,
    output logic RESET_VECTOR,
    output logic HS_OSC_EN,
    output logic OSC_SETTLE_COUNTER_STATUS,
    output logic [7:0] PORT_LATCH_OUT,
    // Peripheral clock enables
    output logic T00_EN,
    output logic ADC_EN,
    output logic CLKMON_EN,
    output logic POC_EN,
    output logic LVI_EN,
    output logic EXTINT_EN,
    output logic T50_EN,
    output logic TH0_EN,
    output logic TH1_EN,
    output logic WDT_EN,
    output logic ASYNC_SERIAL_EN,
    output logic CLOCKED_SERIAL_EN
);
    initial begin
        if (SETTLE_MAX_SEL < 0 || SETTLE_MAX_SEL > 7) begin
            $error("SETTLE_MAX_SEL must lie in 0..7");
        end
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Wake decision from sampled flags
    function automatic smc_act_t decide(input logic mk, input logic pr,
                                        input logic ie, input logic in_service_priority);
        decide = SMC_ACT_HOLD;
        if (!mk) begin
            if (ie && (!pr || in_service_priority)) begin
                decide = SMC_ACT_SERVICE;
            end else begin
                decide = SMC_ACT_NEXT;
            end
        end
    endfunction

    // Settle count for a select value
    function automatic logic [15:0] settle_len(input logic [2:0] sel);
        settle_len = SMC_SETTLE_BASE << sel;
    endfunction

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    smc_state_t state_r;
    smc_act_t act_r;
    logic [31:0] cfg_r;
    logic [31:0] clksel_r;
    logic iosc_off_r;
    logic [15:0] settle_cnt_r;
    logic [3:0] wait_cnt_r;
    logic halt_req_r;
    logic stop_req_r;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic in_stop;
    logic iosc_lock;
    logic [2:0] settle_sel;
    smc_act_t act_now;

    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && PENABLE && !PWRITE;
    assign addr_ok = PADDR == SMC_CTRL_OFS || PADDR == SMC_CFG_OFS ||
                     PADDR == SMC_STAT_OFS || PADDR == SMC_CLKSEL_OFS;
    assign in_stop = state_r == SMC_STOP;
    assign iosc_lock = cfg_r[SMC_CFG_IOSC_LOCK_BIT];
    assign settle_sel = cfg_r[SMC_CFG_SETTLE_LSB +: SMC_CFG_SETTLE_W];
    assign act_now = decide(SOURCE_MASK_FLAG, SOURCE_PRIORITY_FLAG,
                            GLOBAL_IRQ_ENABLE, IN_SERVICE_PRIORITY);

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Zero-wait answer, error on unmapped address
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !addr_ok;
            PRDATA <= 32'h0000_0000;
            if (PSEL && !PENABLE && !PWRITE) begin
                case (PADDR)
                    SMC_CFG_OFS: PRDATA <= cfg_r;
                    SMC_CLKSEL_OFS: PRDATA <= clksel_r;
                    SMC_STAT_OFS: begin
                        PRDATA <= {24'h00_0000, 2'h0, act_r,
                                   OSC_SETTLE_COUNTER_STATUS,
                                   state_r};
                    end
                    SMC_CTRL_OFS: begin
                        PRDATA <= {29'h0000_0000, iosc_off_r,
                                   stop_req_r, halt_req_r};
                    end
                    default: PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration and clock select registers
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cfg_r <= SMC_CFG_RST;
            clksel_r <= SMC_CLKSEL_RST;
        end else if (wr_en && PREADY) begin
            if (PADDR == SMC_CFG_OFS) begin
                cfg_r <= {26'h000_0000, PWDATA[5:0]};
            end
            if (PADDR == SMC_CLKSEL_OFS) begin
                clksel_r <= {26'h000_0000, PWDATA[5:0]};
            end
        end
    end

    // Software standby strobes and internal oscillator stop
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            halt_req_r <= 1'b0;
            stop_req_r <= 1'b0;
            iosc_off_r <= 1'b0;
        end else begin
            halt_req_r <= wr_en && PREADY && PADDR == SMC_CTRL_OFS &&
                          PWDATA[SMC_CTRL_HALT_BIT];
            stop_req_r <= wr_en && PREADY && PADDR == SMC_CTRL_OFS &&
                          PWDATA[SMC_CTRL_STOP_BIT];
            if (wr_en && PREADY && PADDR == SMC_CTRL_OFS) begin
                iosc_off_r <= PWDATA[SMC_CTRL_IOSC_OFF_BIT] && !iosc_lock;
            end
        end
    end

    // ------------------------------------------------------------
    // Standby state machine
    // ------------------------------------------------------------
    // Reset is synchronous and returns to run through the vector
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_r <= SMC_RUN;
            act_r <= SMC_ACT_HOLD;
            settle_cnt_r <= 16'h0000;
            wait_cnt_r <= 4'h0;
        end else begin
            case (state_r)
                SMC_RUN: begin
                    if (STOP_INSN || stop_req_r) begin
                        if (IRQ_PENDING && act_now != SMC_ACT_HOLD) begin
                            act_r <= act_now;
                            state_r <= SMC_SETTLE;
                            settle_cnt_r <= settle_len(settle_sel);
                        end else begin
                            state_r <= SMC_STOP;
                        end
                    end else if (HALT_INSN || halt_req_r) begin
                        state_r <= SMC_HALT;
                    end
                end
                SMC_HALT: begin
                    // Decision sampled at wake time
                    if (IRQ_PENDING && act_now != SMC_ACT_HOLD) begin
                        act_r <= act_now;
                        state_r <= SMC_WAKE;
                        wait_cnt_r <= (act_now == SMC_ACT_SERVICE) ?
                                      SMC_WAIT_VECTOR :
                                      SMC_WAIT_NEXT;
                    end
                end
                SMC_STOP: begin
                    if (IRQ_PENDING && act_now != SMC_ACT_HOLD) begin
                        act_r <= act_now;
                        state_r <= SMC_SETTLE;
                        settle_cnt_r <= settle_len(settle_sel);
                    end
                end
                SMC_SETTLE: begin
                    // RC option needs no settle wait
                    if (cfg_r[SMC_CFG_RC_BIT] || cfg_r[SMC_CFG_CPU_IOSC_BIT] ||
                        settle_cnt_r <= 16'h0001) begin
                        state_r <= SMC_WAKE;
                        wait_cnt_r <= 4'h1;
                    end else begin
                        settle_cnt_r <= settle_cnt_r - 16'h0001;
                    end
                end
                SMC_WAKE: begin
                    if (wait_cnt_r <= 4'h1) begin
                        state_r <= SMC_RUN;
                    end else begin
                        wait_cnt_r <= wait_cnt_r - 4'h1;
                    end
                end
                default: state_r <= SMC_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Core controls
    // ------------------------------------------------------------
    // Clock gate, oscillator, wake pulses, reset vector
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            CPU_CLK_EN <= 1'b0;
            HS_OSC_EN <= 1'b1;
            WAKE_NEXT <= 1'b0;
            WAKE_SERVICE <= 1'b0;
            RESET_VECTOR <= 1'b1;
            OSC_SETTLE_COUNTER_STATUS <= 1'b1;
        end else begin
            CPU_CLK_EN <= state_r == SMC_RUN;
            HS_OSC_EN <= !(in_stop || state_r == SMC_SETTLE) ||
                         cfg_r[SMC_CFG_CPU_IOSC_BIT];
            WAKE_NEXT <= state_r == SMC_WAKE && wait_cnt_r <= 4'h1 &&
                         act_r == SMC_ACT_NEXT;
            WAKE_SERVICE <= state_r == SMC_WAKE && wait_cnt_r <= 4'h1 &&
                            act_r == SMC_ACT_SERVICE;
            RESET_VECTOR <= 1'b0;
            OSC_SETTLE_COUNTER_STATUS <= state_r != SMC_SETTLE;
        end
    end

    // Port latches frozen while stopped
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            PORT_LATCH_OUT <= 8'h00;
        end else if (!in_stop) begin
            PORT_LATCH_OUT <= PORT_LATCH_IN;
        end
    end

    // ------------------------------------------------------------
    // Peripheral clock enables in stop
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            T00_EN <= 1'b1;
            ADC_EN <= 1'b1;
            CLKMON_EN <= 1'b1;
            POC_EN <= 1'b1;
            LVI_EN <= 1'b1;
            EXTINT_EN <= 1'b1;
            T50_EN <= 1'b1;
            TH0_EN <= 1'b1;
            TH1_EN <= 1'b1;
            WDT_EN <= 1'b1;
            ASYNC_SERIAL_EN <= 1'b1;
            CLOCKED_SERIAL_EN <= 1'b1;
        end else begin
            T00_EN <= !in_stop;
            ADC_EN <= !in_stop;
            CLKMON_EN <= !in_stop;
            POC_EN <= 1'b1;
            LVI_EN <= 1'b1;
            EXTINT_EN <= 1'b1;
            T50_EN <= !in_stop || clksel_r[SMC_SEL_T50_EXT_BIT];
            TH0_EN <= !in_stop || (clksel_r[SMC_SEL_H0_T50_BIT] &&
                      clksel_r[SMC_SEL_T50_RUN_BIT]);
            TH1_EN <= !iosc_off_r && (!in_stop ||
                      clksel_r[SMC_SEL_H1_DIV7_BIT]);
            WDT_EN <= iosc_lock || !in_stop;
            ASYNC_SERIAL_EN <= !in_stop || (clksel_r[SMC_SEL_UART_T50_BIT] &&
                               clksel_r[SMC_SEL_T50_RUN_BIT]);
            CLOCKED_SERIAL_EN <= !in_stop ||
                                 clksel_r[SMC_SEL_CSI_EXT_BIT];
        end
    end
endmodule

//--- tb/smc_chk.sv
// Checker: port-level properties of the standby controller.
// Assumes it is bound into smc_top; one clock domain.
`timescale 1ns/100ps
module smc_chk (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Core strobes, flags and port latch input
    input wire logic STOP_INSN,
    input wire logic IRQ_PENDING,
    input wire logic SOURCE_MASK_FLAG,
    input wire logic [7:0] PORT_LATCH_IN,
    // Controller outputs
    input wire logic CPU_CLK_EN,
    input wire logic WAKE_NEXT,
    input wire logic WAKE_SERVICE,
    input wire logic RESET_VECTOR,
    input wire logic [7:0] PORT_LATCH_OUT,
    input wire logic T00_EN,
    input wire logic ADC_EN,
    input wire logic CLKMON_EN,
    input wire logic POC_EN,
    input wire logic LVI_EN,
    input wire logic EXTINT_EN
);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // Stop taken with no unmasked request waiting
    wire logic stop_go = STOP_INSN && CPU_CLK_EN
        && !(IRQ_PENDING && !SOURCE_MASK_FLAG);
    wire logic wake_any = WAKE_NEXT || WAKE_SERVICE;
    a_reset_exit: assert property (
        $rose(RST_N) |-> RESET_VECTOR ##1 (!RESET_VECTOR && CPU_CLK_EN))
        else $error("reset exit wrong");
    a_wake_exclusive: assert property (
        !(WAKE_NEXT && WAKE_SERVICE)) else $error("both wake kinds");
    a_wake_pulse: assert property (
        wake_any |=> !wake_any) else $error("wake pulse too long");
    a_wake_restart: assert property (
        wake_any |-> !CPU_CLK_EN ##[1:3] CPU_CLK_EN)
        else $error("cpu clock not restored");
    a_stop_clock: assert property (
        stop_go |-> ##2 !CPU_CLK_EN [*3]) else $error("cpu clock in stop");
    a_stop_periph: assert property (
        stop_go |=> ##1 !(T00_EN || ADC_EN || CLKMON_EN))
        else $error("peripheral running in stop");
    a_always_on: assert property (
        POC_EN && LVI_EN && EXTINT_EN) else $error("monitor disabled");
    a_port_copy: assert property (
        CPU_CLK_EN |-> PORT_LATCH_OUT == $past(PORT_LATCH_IN))
        else $error("port latch not copied");
    a_port_frozen: assert property (
        stop_go |-> ##3 $stable(PORT_LATCH_OUT) [*4])
        else $error("port latch moved in stop");
    // Main scenarios reached
    c_service: cover property (WAKE_SERVICE);
    c_next: cover property (WAKE_NEXT);
    c_stop: cover property (stop_go);
endmodule

bind smc_top smc_chk u_chk (
    .SYS_CLK, .RST_N, .STOP_INSN, .IRQ_PENDING, .SOURCE_MASK_FLAG,
    .PORT_LATCH_IN, .CPU_CLK_EN, .WAKE_NEXT, .WAKE_SERVICE, .RESET_VECTOR,
    .PORT_LATCH_OUT, .T00_EN, .ADC_EN, .CLKMON_EN, .POC_EN, .LVI_EN,
    .EXTINT_EN
);

//--- tb/smc_core_model.sv
// Core and interrupt flag model facing the standby controller.
// Assumes the bench commands it with one-cycle strobes.
`timescale 1ns/100ps
module smc_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench commands
    input wire logic do_halt,
    input wire logic do_stop,
    input wire logic irq_set,
    input wire logic [3:0] flags,
    // Controller feedback
    input wire logic cpu_clk_en,
    input wire logic wake_any,
    // Core outputs
    output logic halt_insn,
    output logic stop_insn,
    output logic irq_pending,
    output logic [3:0] irq_flags
);
    // Standby instructions issue only while the core is clocked
    always_ff @(posedge clk) begin
        halt_insn <= rst_n && do_halt && cpu_clk_en;
        stop_insn <= rst_n && do_stop && cpu_clk_en;
    end
    // Request flag: set by a source, dropped on acknowledge or reset
    always_ff @(posedge clk) begin
        if (!rst_n || wake_any) begin
            irq_pending <= 1'h0;
            irq_flags <= 4'h8;
        end else if (irq_set) begin
            irq_pending <= 1'h1;
            irq_flags <= flags;
        end
    end
endmodule

//--- tb/test_standby_mode_control.sv
// Testbench: standby controller with core model and APB master.
// Assumes smc_pkg, smc_top, smc_core_model, smc_chk compiled first.
`timescale 1ns/100ps
module test_standby_mode_control
    import smc_pkg::*;
;
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic do_halt = 1'h0, do_stop = 1'h0, irq_set = 1'h0;
    logic [3:0] flg = 4'h0;
    logic [7:0] paddr = 8'h0, port_in = 8'h0;
    logic [31:0] pwdata = 32'h0, seed = 32'hDA5A_C2D0;
    logic [31:0] pseed = 32'hDA5A_C2D0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, halt_i, stop_i, irqp, cpu_en, wnx, wsv;
    wire logic rvec, hs_en, sts;
    wire logic [3:0] irqf;
    wire logic [7:0] port_out;
    wire logic [11:0] pe;
    int failures = 0, compares = 0;
    always #25 clk = ~clk;
    smc_top u_dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .HALT_INSN(halt_i), .STOP_INSN(stop_i), .IRQ_PENDING(irqp),
        .SOURCE_MASK_FLAG(irqf[3]), .SOURCE_PRIORITY_FLAG(irqf[2]),
        .GLOBAL_IRQ_ENABLE(irqf[1]), .IN_SERVICE_PRIORITY(irqf[0]),
        .PORT_LATCH_IN(port_in), .CPU_CLK_EN(cpu_en), .WAKE_NEXT(wnx),
        .WAKE_SERVICE(wsv), .RESET_VECTOR(rvec), .HS_OSC_EN(hs_en),
        .OSC_SETTLE_COUNTER_STATUS(sts), .PORT_LATCH_OUT(port_out),
        .T00_EN(pe[11]), .ADC_EN(pe[10]), .CLKMON_EN(pe[9]), .POC_EN(pe[8]),
        .LVI_EN(pe[7]), .EXTINT_EN(pe[6]), .T50_EN(pe[5]), .TH0_EN(pe[4]),
        .TH1_EN(pe[3]), .WDT_EN(pe[2]), .ASYNC_SERIAL_EN(pe[1]),
        .CLOCKED_SERIAL_EN(pe[0]));
    smc_core_model u_core (.clk(clk), .rst_n(rst_n), .do_halt(do_halt),
        .do_stop(do_stop), .irq_set(irq_set), .flags(flg),
        .cpu_clk_en(cpu_en), .wake_any(wnx || wsv), .halt_insn(halt_i),
        .stop_insn(stop_i), .irq_pending(irqp), .irq_flags(irqf));
    // Random port latch values every cycle
    always @(posedge clk) begin
        pseed <= lfsr(pseed);
        port_in <= pseed[7:0];
    end
    // -------------------------------------------
    // Helpers
    // -------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Expected outcome: 0 hold, 1 next instruction, 2 service
    function automatic logic [1:0] exp_act(input logic [3:0] f);
        if (f[3]) return 2'h0;
        return (f[1] && (!f[2] || f[0])) ? 2'h2 : 2'h1;
    endfunction
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'h1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One APB transfer; holds the request until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (n >= 16) begin
            failures++;
            give_verdict();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk);
    endtask
    task automatic do_reset;
        rst_n <= 1'h0;
        repeat (16) @(posedge clk);
        chk(rvec === 1'h1 && cpu_en === 1'h0, "in reset");
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
        chk(rvec === 1'h0 && cpu_en === 1'h1, "reset exit");
    endtask
    // Count cycles to a wake pulse; k is {service, next}
    task automatic wake(input int lim, output int n, output logic [1:0] k);
        n = 0;
        k = 2'h0;
        while (n < lim && k == 2'h0) begin
            @(posedge clk);
            n++;
            k = {wsv === 1'h1, wnx === 1'h1};
        end
    endtask
    task automatic raise(input logic [3:0] f);
        flg <= f;
        irq_set <= 1'h1;
        @(posedge clk);
        irq_set <= 1'h0;
    endtask
    // -------------------------------------------
    // Main sequence
    // -------------------------------------------
    initial begin
        logic [31:0] q;
        logic e, lk, off, rc, io;
        logic [1:0] x, k;
        logic [3:0] f;
        logic [5:0] s;
        logic [7:0] po;
        int n;
        do_reset();
        apb(1'h0, SMC_CFG_OFS, 32'h0, q, e);
        chk(q === SMC_CFG_RST && e === 1'h0, "cfg reset");
        apb(1'h0, SMC_CLKSEL_OFS, 32'h0, q, e);
        chk(q === SMC_CLKSEL_RST, "clksel reset");
        apb(1'h1, 8'h10, 32'hFFFF_FFFF, q, e);
        chk(e === 1'h1, "unmapped write");
        apb(1'h0, 8'h10, 32'h0, q, e);
        chk(e === 1'h1 && q === 32'h0, "unmapped read");
        $display("test registers done");
        // Halt wake decision: every flag combination, then random ones
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            f = (i < 16) ? 4'(i) : seed[3:0];
            x = exp_act(f);
            if (i == 0) begin
                // Software halt strobe through the control register
                apb(1'h1, SMC_CTRL_OFS, 32'h0000_0001, q, e);
            end else begin
                do_halt <= 1'h1;
                @(posedge clk);
                do_halt <= 1'h0;
            end
            repeat (4) @(posedge clk);
            chk(cpu_en === 1'h0, "halt clock");
            raise(f);
            wake(40, n, k);
            chk(k === x, "wake kind");
            if (x == 2'h2) chk(n >= 8 && n <= 12, "service wait");
            if (x == 2'h1) chk(n >= 2 && n <= 6, "next wait");
            if (x == 2'h0) do_reset();
            repeat (4) @(posedge clk);
        end
        $display("test halt done");
        // Stop: gating, enables, settle wait, skip and collapse
        for (int j = 0; j < 4; j++) begin
            seed = lfsr(seed);
            s = seed[5:0];
            lk = seed[6];
            rc = (j == 1);
            io = (j == 2);
            off = seed[7] & !io;
            apb(1'h1, SMC_CFG_OFS, {26'h0, io, lk, rc, 3'h0}, q, e);
            apb(1'h1, SMC_CLKSEL_OFS, {26'h0, s}, q, e);
            apb(1'h1, SMC_CTRL_OFS, {29'h0, off, 2'h0}, q, e);
            apb(1'h0, SMC_CFG_OFS, 32'h0, q, e);
            chk(q[5:0] === {io, lk, rc, 3'h0}, "cfg readback");
            if (j == 3) raise(4'h2);
            do_stop <= 1'h1;
            @(posedge clk);
            do_stop <= 1'h0;
            repeat (3) @(posedge clk);
            po = port_out;
            chk(cpu_en === 1'h0, "stop clock");
            chk(sts === (j != 3), "settle status");
            if (j < 3) begin
                chk(hs_en === io, "hs osc");
                chk(pe[11:6] === 6'h07, "fixed enables");
                chk(pe[5:3] === {s[0], s[2] & s[1],
                    s[3] & !(off & !lk)}, "timers");
                chk(pe[2:0] === {lk, s[4] & s[1], s[5]}, "wdt serial");
                repeat (5) @(posedge clk);
                chk(port_out === po, "port hold");
                apb(1'h0, SMC_STAT_OFS, 32'h0, q, e);
                chk(q[2:0] === 3'h2 && e === 1'h0, "stat stop");
                raise(4'h2);
            end
            wake(60, n, k);
            chk(k === 2'h2, "stop wake");
            if (k == 2'h0) give_verdict();
            if (!rc && !io) chk(n >= (j == 0 ? 16 : 12), "settle");
            if (rc || io) chk(n < 12, "settle skip");
            repeat (4) @(posedge clk);
        end
        $display("test stop done");
        give_verdict();
    end
endmodule
